// [core_mem_pkg.sv]
// constants for the core memory organization block
// assumes a single core clock and an active-low asynchronous reset
package core_mem_pkg;
   // ---------------------------------------------
   // core register offsets inside every bank
   // ---------------------------------------------
   localparam logic [6:0] OFS_IND0    = 7'h00;
   localparam logic [6:0] OFS_IND1    = 7'h01;
   localparam logic [6:0] OFS_PCL     = 7'h02;
   localparam logic [6:0] OFS_STATUS  = 7'h03;
   localparam logic [6:0] OFS_P0L     = 7'h04;
   localparam logic [6:0] OFS_P0H     = 7'h05;
   localparam logic [6:0] OFS_P1L     = 7'h06;
   localparam logic [6:0] OFS_P1H     = 7'h07;
   localparam logic [6:0] OFS_BSR     = 7'h08;
   localparam logic [6:0] OFS_WORKING_REG    = 7'h09;
   localparam logic [6:0] OFS_PC_HIGH_LATCH  = 7'h0a;
   localparam logic [6:0] OFS_INTCTL  = 7'h0b;
   // ---------------------------------------------
   // bank partitioning
   // ---------------------------------------------
   localparam logic [6:0] SFR_LAST     = 7'h1f;
   localparam logic [6:0] GPR_FIRST    = 7'h20;
   localparam logic [6:0] GPR_LAST     = 7'h6f;
   localparam logic [6:0] COMMON_FIRST = 7'h70;
   localparam int         GPR_PER_BANK = 80;
   localparam int         COMMON_BYTES = 16;
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   // ---------------------------------------------
   // program space, vectors, stack
   // ---------------------------------------------
   localparam int          PC_W        = 15;
   localparam int          PROG_SEL    = 15;
   localparam logic [14:0] RESET_VEC   = 15'h0000;
   localparam logic [14:0] IRQ_VEC     = 15'h0004;
   localparam int          HEF_WORDS   = 128;
   localparam int          STACK_DEPTH = 16;
   // ---------------------------------------------
   // status bit positions and reset values
   // ---------------------------------------------
   localparam int ST_C  = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z  = 2;
   localparam logic [2:0] FLAG_Z_MASK = 3'h4;
   localparam logic FLAG_RST = 1'b0;
   localparam logic TOPD_RST = 1'b1;
   typedef enum logic [1:0] {ACC_DIRECT, ACC_PTR0, ACC_PTR1} acc_mode_t;
   typedef enum logic [1:0] {RG_NONE, RG_CORE, RG_RAM, RG_PROG} region_t;
endpackage

// [core_memory_organization.sv]
// core memory organization: pc, stack, pointers, banked data memory
// assumes the execution logic drives one access at a time and a
// flash that answers the cycle pfm_rd is high
// Function
// [RULE_01] shadow core registers on interrupt, restore on return
// [RULE_02] separate 16 x 15 bit return stack
// [RULE_03] stack over/underflow flags, optional software reset
// [RULE_04] two 16-bit pointers reach all memory
// [RULE_05] program reads via pointer take extra cycle
// [RULE_06] general ram also reachable as linear region
// [RULE_07] program counter is 15 bits wide
// [RULE_08] program addresses wrap within implemented size
// [RULE_09] reset vector 0000h, interrupt vector 0004h
// [RULE_10] top 128 program words are high endurance
// [RULE_11] pointer high bit 7 selects program memory
// [RULE_12] program read returns low eight bits
// [RULE_13] pointer writes never modify program memory
// [RULE_14] 32 banks: core, sfr, general, common ram
// [RULE_15] direct accesses use bank select register
// [RULE_16] unimplemented data locations read zero
// [RULE_17] 12-bit data address: bank and offset
// [RULE_18] core registers mirrored at bank start
// [RULE_19] computed flags override status writes
// [RULE_20] timeout and powerdown flags ignore writes
// [RULE_21] clearing status zeros top, sets zero
// [RULE_22] subtraction flags are inverted borrows
// [RULE_23] powerdown flag set/cleared by power, sleep
// [RULE_24] timeout flag set by ops, cleared by expiry
// [RULE_25] sfr space follows core registers
`timescale 1ns/1ps
module core_memory_organization #(
   parameter int PROG_WORDS = 16384,
   parameter int GPR_BANKS  = 4
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // data access from execution logic
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic [1:0]  acc_mode,
   input  wire logic [6:0]  acc_offset,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        clear_file_op,
   output logic [7:0]       acc_rdata,
   output logic             acc_done,
   output logic             acc_busy,
   // alu flag results and working register write
   input  wire logic [2:0]  alu_flag_mask,
   input  wire logic [2:0]  alu_flags,
   input  wire logic        alu_is_sub,
   input  wire logic        working_reg_we,
   input  wire logic [7:0]  working_reg_wdata,
   // program flow
   input  wire logic        pc_advance,
   input  wire logic        jump_op,
   input  wire logic        call_op,
   input  wire logic        ret_op,
   input  wire logic        irq_take,
   input  wire logic        ret_irq,
   input  wire logic [14:0] jump_target,
   // power and watchdog events, stack controls
   input  wire logic        sleep_op,
   input  wire logic        watchdog_clear_op,
   input  wire logic        wdt_expire,
   input  wire logic        stack_reset_en,
   input  wire logic        stack_flag_clear,
   // program flash read port
   input  wire logic [13:0] pfm_rdata,
   output logic             pfm_rd,
   output logic [14:0]      pfm_addr,
   output logic             pfm_hef,
   // core state
   output logic [14:0]      pc,
   output logic [7:0]       working_reg,
   output logic [7:0]       status_flags,
   output logic [7:0]       interrupt_control_reg,
   output logic             stack_overflow_flag,
   output logic             stack_underflow_flag,
   output logic             soft_reset
);
   localparam int LIN_BYTES = GPR_BANKS * core_mem_pkg::GPR_PER_BANK;
   localparam int RAM_BYTES = LIN_BYTES + core_mem_pkg::COMMON_BYTES;
   localparam int RAM_AW    = $clog2(RAM_BYTES);
   localparam logic [14:0] PC_MASK  = 15'(PROG_WORDS - 1);
   localparam logic [14:0] HEF_BASE = 15'(PROG_WORDS - core_mem_pkg::HEF_WORDS);

   typedef enum logic {ST_IDLE, ST_PROG} acc_state_t;
   acc_state_t state;

   logic [7:0]  pointer0_low, pointer0_high, pointer1_low, pointer1_high;
   logic [4:0]  bank_select_reg;
   logic [6:0]  pc_high_latch;
   logic        watchdog_expiry_flag, powerdown_flag, zf, nibble_overflow_bit, cf;
   logic [4:0]  sp;
   logic [14:0] stack [core_mem_pkg::STACK_DEPTH];
   logic [7:0]  ram [RAM_BYTES];
   logic [7:0]  sh_working_reg, sh_p0l, sh_p0h, sh_p1l, sh_p1h;
   logic [4:0]  sh_bsr;
   logic [6:0]  sh_pc_high_latch;
   logic [2:0]  sh_flags;

   // ---------------------------------------------
   // address resolve
   // ---------------------------------------------
   logic [15:0]        ea;
   logic [15:0]        lin_off;
   logic [6:0]         off;
   logic [4:0]         bnk;
   core_mem_pkg::region_t region;
   logic [RAM_AW-1:0]  ram_idx;
   logic [7:0]         core_rd;
   logic               take, wr_core, wr_ram, st_wr;

   always_comb begin
      case (acc_mode)
         core_mem_pkg::ACC_PTR0: ea = {pointer0_high, pointer0_low};   // [RULE_04]
         core_mem_pkg::ACC_PTR1: ea = {pointer1_high, pointer1_low};
         default: ea = {4'h0, bank_select_reg, acc_offset};            // [RULE_15]
      endcase
      off     = ea[6:0];                                               // [RULE_17]
      bnk     = ea[11:7];
      lin_off = ea - core_mem_pkg::LINEAR_BASE;
      region  = core_mem_pkg::RG_NONE;
      ram_idx = '0;
      if (ea[core_mem_pkg::PROG_SEL]) begin
         region = core_mem_pkg::RG_PROG;                               // [RULE_11]
      end else if (ea[15:12] == 4'h0) begin
         if (off <= core_mem_pkg::OFS_INTCTL) begin
            region = core_mem_pkg::RG_CORE;                            // [RULE_14]
         end else if (off <= core_mem_pkg::SFR_LAST) begin
            region = core_mem_pkg::RG_NONE;                            // [RULE_25]
         end else if (off <= core_mem_pkg::GPR_LAST) begin
            if (int'(bnk) < GPR_BANKS) begin
               region  = core_mem_pkg::RG_RAM;
               ram_idx = RAM_AW'(int'(bnk) * core_mem_pkg::GPR_PER_BANK
                         + int'(off) - int'(core_mem_pkg::GPR_FIRST));
            end
         end else begin
            region  = core_mem_pkg::RG_RAM;
            ram_idx = RAM_AW'(LIN_BYTES + int'(off - core_mem_pkg::COMMON_FIRST));
         end
      end else if (ea >= core_mem_pkg::LINEAR_BASE && lin_off < 16'(LIN_BYTES)) begin
         region  = core_mem_pkg::RG_RAM;                               // [RULE_06]
         ram_idx = RAM_AW'(lin_off);
      end
   end

   // core register read mux, indirect ports read back zero
   always_comb begin
      case (off)
         core_mem_pkg::OFS_PCL:    core_rd = pc[7:0];                  // [RULE_18]
         core_mem_pkg::OFS_STATUS: core_rd = status_flags;
         core_mem_pkg::OFS_P0L:    core_rd = pointer0_low;
         core_mem_pkg::OFS_P0H:    core_rd = pointer0_high;
         core_mem_pkg::OFS_P1L:    core_rd = pointer1_low;
         core_mem_pkg::OFS_P1H:    core_rd = pointer1_high;
         core_mem_pkg::OFS_BSR:    core_rd = {3'h0, bank_select_reg};
         core_mem_pkg::OFS_WORKING_REG:   core_rd = working_reg;
         core_mem_pkg::OFS_PC_HIGH_LATCH: core_rd = {1'b0, pc_high_latch};
         core_mem_pkg::OFS_INTCTL: core_rd = interrupt_control_reg;
         default:                  core_rd = 8'h00;
      endcase
   end

   assign take    = acc_valid && (state == ST_IDLE);
   assign wr_core = take && acc_write && (region == core_mem_pkg::RG_CORE);
   assign wr_ram  = take && acc_write && (region == core_mem_pkg::RG_RAM);  // [RULE_13]
   assign st_wr   = wr_core && (off == core_mem_pkg::OFS_STATUS);

   // ---------------------------------------------
   // access sequencing
   // ---------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state     <= ST_IDLE;
         acc_rdata <= 8'h00;
         acc_done  <= 1'b0;
         acc_busy  <= 1'b0;
         pfm_rd    <= 1'b0;
         pfm_addr  <= 15'h0000;
         pfm_hef   <= 1'b0;
      end else begin
         acc_done <= 1'b0;
         pfm_rd   <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take) begin
                  if (!acc_write && region == core_mem_pkg::RG_PROG) begin
                     state    <= ST_PROG;                              // [RULE_05]
                     acc_busy <= 1'b1;
                     pfm_rd   <= 1'b1;
                     pfm_addr <= ea[14:0] & PC_MASK;                   // [RULE_08]
                     pfm_hef  <= (ea[14:0] & PC_MASK) >= HEF_BASE;     // [RULE_10]
                  end else begin
                     acc_done <= 1'b1;
                     case (region)
                        core_mem_pkg::RG_CORE: acc_rdata <= core_rd;
                        core_mem_pkg::RG_RAM:  acc_rdata <= ram[ram_idx];
                        default:               acc_rdata <= 8'h00;     // [RULE_16]
                     endcase
                  end
               end
            end
            ST_PROG: begin
               state     <= ST_IDLE;
               acc_busy  <= 1'b0;
               acc_done  <= 1'b1;
               acc_rdata <= pfm_rdata[7:0];                            // [RULE_12]
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (wr_ram) begin
         ram[ram_idx] <= acc_wdata;
      end
   end

   // ---------------------------------------------
   // core registers and shadow copies
   // ---------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {pointer0_low, pointer0_high, pointer1_low, pointer1_high} <= 32'h0;
         bank_select_reg <= 5'h00;
         working_reg     <= 8'h00;
         pc_high_latch   <= 7'h00;
         interrupt_control_reg <= 8'h00;
         {sh_working_reg, sh_p0l, sh_p0h, sh_p1l, sh_p1h} <= 40'h0;
         sh_bsr    <= 5'h00;
         sh_pc_high_latch <= 7'h00;
      end else if (ret_irq) begin
         working_reg     <= sh_working_reg;                                   // [RULE_01]
         pointer0_low    <= sh_p0l;
         pointer0_high   <= sh_p0h;
         pointer1_low    <= sh_p1l;
         pointer1_high   <= sh_p1h;
         bank_select_reg <= sh_bsr;
         pc_high_latch   <= sh_pc_high_latch;
      end else begin
         if (irq_take) begin
            sh_working_reg   <= working_reg;                                  // [RULE_01]
            sh_p0l    <= pointer0_low;
            sh_p0h    <= pointer0_high;
            sh_p1l    <= pointer1_low;
            sh_p1h    <= pointer1_high;
            sh_bsr    <= bank_select_reg;
            sh_pc_high_latch <= pc_high_latch;
         end
         if (working_reg_we) begin
            working_reg <= working_reg_wdata;
         end
         if (wr_core) begin
            case (off)
               core_mem_pkg::OFS_P0L:    pointer0_low    <= acc_wdata;
               core_mem_pkg::OFS_P0H:    pointer0_high   <= acc_wdata;
               core_mem_pkg::OFS_P1L:    pointer1_low    <= acc_wdata;
               core_mem_pkg::OFS_P1H:    pointer1_high   <= acc_wdata;
               core_mem_pkg::OFS_BSR:    bank_select_reg <= acc_wdata[4:0];
               core_mem_pkg::OFS_WORKING_REG:   working_reg     <= acc_wdata;
               core_mem_pkg::OFS_PC_HIGH_LATCH: pc_high_latch   <= acc_wdata[6:0];
               core_mem_pkg::OFS_INTCTL: interrupt_control_reg <= acc_wdata;
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // status register
   // ---------------------------------------------
   logic [2:0] fmask, fval;
   always_comb begin
      fmask = alu_flag_mask;
      fval  = alu_flags;
      if (alu_is_sub) begin
         fval[core_mem_pkg::ST_C]  = ~alu_flags[core_mem_pkg::ST_C];   // [RULE_22]
         fval[core_mem_pkg::ST_DC] = ~alu_flags[core_mem_pkg::ST_DC];
      end
      if (clear_file_op) begin
         fmask = core_mem_pkg::FLAG_Z_MASK;                            // [RULE_21]
         fval  = core_mem_pkg::FLAG_Z_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_expiry_flag <= core_mem_pkg::TOPD_RST;               // [RULE_23]
         powerdown_flag       <= core_mem_pkg::TOPD_RST;
         {zf, nibble_overflow_bit, cf} <= {3{core_mem_pkg::FLAG_RST}};
         sh_flags <= 3'h0;
      end else begin
         if (watchdog_clear_op) begin
            powerdown_flag       <= 1'b1;                              // [RULE_23]
            watchdog_expiry_flag <= 1'b1;                              // [RULE_24]
         end else if (sleep_op) begin
            powerdown_flag       <= 1'b0;
            watchdog_expiry_flag <= 1'b1;
         end
         if (wdt_expire) begin
            watchdog_expiry_flag <= 1'b0;                              // [RULE_24]
         end
         if (irq_take) begin
            sh_flags <= {zf, nibble_overflow_bit, cf};
         end
         if (ret_irq) begin
            {zf, nibble_overflow_bit, cf} <= sh_flags;
         end else if (fmask != 3'h0) begin
            if (fmask[core_mem_pkg::ST_Z])  zf  <= fval[core_mem_pkg::ST_Z];   // [RULE_19]
            if (fmask[core_mem_pkg::ST_DC]) nibble_overflow_bit <= fval[core_mem_pkg::ST_DC];
            if (fmask[core_mem_pkg::ST_C])  cf  <= fval[core_mem_pkg::ST_C];
         end else if (st_wr) begin
            {zf, nibble_overflow_bit, cf} <= acc_wdata[2:0];           // [RULE_20]
         end
      end
   end

   // upper three bits are unimplemented and read zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_flags <= 8'h18;
      end else begin
         status_flags <= 8'h00;
         status_flags[4:0] <= {watchdog_expiry_flag, powerdown_flag, zf,
                               nibble_overflow_bit, cf};               // [RULE_21]
      end
   end

   // ---------------------------------------------
   // program counter and return stack
   // ---------------------------------------------
   logic push, pop, ovf_evt, unf_evt;
   assign push    = irq_take || (call_op && !ret_op && !ret_irq);
   assign pop     = !irq_take && (ret_op || ret_irq);
   assign ovf_evt = push && (sp == 5'(core_mem_pkg::STACK_DEPTH));
   assign unf_evt = pop && (sp == 5'h00);

   always_ff @(posedge clk) begin
      if (push && !ovf_evt) begin
         stack[sp[3:0]] <= pc;                                         // [RULE_02]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc <= core_mem_pkg::RESET_VEC;                                // [RULE_09]
         sp <= 5'h00;
         stack_overflow_flag  <= 1'b0;
         stack_underflow_flag <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= (ovf_evt || unf_evt) && stack_reset_en;         // [RULE_03]
         if (stack_flag_clear) begin
            stack_overflow_flag  <= 1'b0;
            stack_underflow_flag <= 1'b0;
         end
         if (ovf_evt) stack_overflow_flag  <= 1'b1;                    // [RULE_03]
         if (unf_evt) stack_underflow_flag <= 1'b1;
         if (push && !ovf_evt) sp <= sp + 5'h01;
         if (pop && !unf_evt)  sp <= sp - 5'h01;
         if (irq_take) begin
            pc <= core_mem_pkg::IRQ_VEC;                               // [RULE_09]
         end else if (pop) begin
            pc <= unf_evt ? core_mem_pkg::RESET_VEC : stack[4'(sp - 5'h01)];
         end else if (call_op || jump_op) begin
            pc <= jump_target & PC_MASK;                               // [RULE_08]
         end else if (wr_core && off == core_mem_pkg::OFS_PCL) begin
            pc <= {pc_high_latch, acc_wdata} & PC_MASK;                // [RULE_07]
         end else if (pc_advance) begin
            pc <= 15'(pc + 15'h0001) & PC_MASK;
         end
      end
   end

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_irq_vec;
      irq_take |=> pc == core_mem_pkg::IRQ_VEC;
   endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("irq vector wrong"); // [RULE_09]

   property p_prog_extra;
      take && !acc_write && region == core_mem_pkg::RG_PROG
         |=> pfm_rd && !acc_done ##1 acc_done && !acc_busy;
   endproperty
   a_prog_extra: assert property (p_prog_extra) else $error("prog read timing"); // [RULE_05]

   property p_prog_low;
      pfm_rd |=> acc_rdata == $past(pfm_rdata[7:0]);
   endproperty
   a_prog_low: assert property (p_prog_low) else $error("prog byte wrong"); // [RULE_12]

   property p_unimpl_zero;
      take && !acc_write && region == core_mem_pkg::RG_NONE |=> acc_done && acc_rdata == 8'h00;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl not zero"); // [RULE_16]

   property p_no_prog_write;
      take && acc_write && ea[core_mem_pkg::PROG_SEL] |-> !wr_ram && !wr_core;
   endproperty
   a_no_prog_write: assert property (p_no_prog_write) else $error("prog written"); // [RULE_13]

   property p_ovf;
      ovf_evt |=> stack_overflow_flag && sp == 5'h10 && soft_reset == $past(stack_reset_en);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // [RULE_03]

   property p_unf;
      unf_evt |=> stack_underflow_flag && sp == 5'h00;
   endproperty
   a_unf: assert property (p_unf) else $error("underflow not flagged"); // [RULE_03]

   property p_wrap;
      (pc & ~PC_MASK) == 15'h0000 && (pfm_addr & ~PC_MASK) == 15'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address past memory"); // [RULE_08]

   property p_topd_ro;
      st_wr && !sleep_op && !watchdog_clear_op && !wdt_expire
         |=> $stable(watchdog_expiry_flag) && $stable(powerdown_flag);
   endproperty
   a_topd_ro: assert property (p_topd_ro) else $error("to/pd written"); // [RULE_20]

   property p_flag_win;
      st_wr && clear_file_op && !ret_irq |=> zf && $stable(cf) && $stable(nibble_overflow_bit);
   endproperty
   a_flag_win: assert property (p_flag_win) else $error("status clear wrong"); // [RULE_21]

   property p_restore;
      irq_take && !working_reg_we && !wr_core ##1 ret_irq[*1] |=> working_reg == $past(working_reg, 2);
   endproperty
   a_restore: assert property (p_restore) else $error("shadow restore wrong"); // [RULE_01]

   c_prog_read: cover property (pfm_rd ##1 acc_done);
   c_irq_ret:   cover property (irq_take ##[1:20] ret_irq);
   c_overflow:  cover property (ovf_evt);
   c_linear:    cover property (take && ea[15:13] == 3'h1 && region == core_mem_pkg::RG_RAM);
endmodule // core_memory_organization

// [prog_flash_model.sv]
// program flash stand-in for the core memory block
// assumes strobe and address change just after the rising clock edge
`timescale 1ns/1ps
module prog_flash_model (
   // read port
   input  wire logic [14:0] pfm_addr,
   input  wire logic        pfm_rd,
   output logic [13:0]      pfm_rdata
);
   logic [13:0] word;
   // 14-bit word pattern of the address, inverted while not strobed
   always_comb word = pfm_addr[13:0] ^ 14'h2b5c;
   always_comb pfm_rdata = pfm_rd ? word : ~word;
endmodule // prog_flash_model

// [tb_core_memory_organization.sv]
// self-checking bench for the core memory organization block
// assumes the flash stand-in answers in the cycle of its strobe
`timescale 1ns/1ps
module tb_core_memory_organization;
   logic clk = 1'b0, rst_b = 1'b0, v = 1'b0, wr = 1'b0, cfo = 1'b0, sub = 1'b0, sre = 1'b0;
   logic [1:0] md = 2'h0;
   logic [2:0] fm = 3'h0;
   logic [6:0] ofs = 7'h00;
   logic [7:0] wd = 8'h00, rd, sts;
   logic [9:0] ev = 10'h000;
   logic [13:0] prd;
   logic [14:0] pa, pc;
   logic done, busy, prd_s, ovf, unf, hef, srst;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   core_memory_organization DUT (.clk(clk), .rst_b(rst_b), .acc_valid(v), .acc_write(wr),
      .acc_mode(md), .acc_offset(ofs), .acc_wdata(wd), .clear_file_op(cfo), .acc_rdata(rd),
      .acc_done(done), .acc_busy(busy), .alu_flag_mask(fm), .alu_flags(3'h0),
      .alu_is_sub(sub), .working_reg_we(1'b0), .working_reg_wdata(8'h00), .pc_advance(ev[0]),
      .jump_op(ev[1]), .call_op(ev[2]), .ret_op(ev[3]), .irq_take(ev[4]), .ret_irq(ev[5]),
      .jump_target(15'h0123), .sleep_op(ev[6]), .watchdog_clear_op(ev[7]),
      .wdt_expire(ev[8]), .stack_reset_en(sre), .stack_flag_clear(ev[9]), .pfm_rdata(prd),
      .pfm_rd(prd_s), .pfm_addr(pa), .pfm_hef(hef), .pc(pc), .working_reg(),
      .status_flags(sts), .interrupt_control_reg(), .stack_overflow_flag(ovf),
      .stack_underflow_flag(unf), .soft_reset(srst));
   prog_flash_model flash (.pfm_addr(pa), .pfm_rd(prd_s), .pfm_rdata(prd));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (exp !== got) begin
         error_cnt++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // one access, answer awaited at most four cycles
   task automatic acc(input logic w, input logic [1:0] m, input logic [6:0] o,
                      input logic [7:0] d, input logic [15:0] exp);
      int n;
      @(negedge clk) begin v = 1'b1; wr = w; md = m; ofs = o; wd = d; end
      @(negedge clk) v = 1'b0;
      for (n = 0; n < 4 && done !== 1'b1; n++) @(negedge clk);
      chk(16'h0001, {15'h0, done});
      if (!w) chk(exp, {8'h00, rd});
   endtask
   task automatic pulse(input int i);
      @(negedge clk) ev[i] = 1'b1;
      @(negedge clk) ev = 10'h000;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin error_cnt++; end_sim(); end
   end
   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      chk(16'h0000, {1'b0, pc});
      chk(16'h0018, {8'h00, sts});
      $display("reset test done");
      acc(1'b1, 2'h0, 7'h08, 8'h01, 16'h0);
      acc(1'b1, 2'h0, 7'h20, 8'ha5, 16'h0);
      acc(1'b0, 2'h0, 7'h20, 8'h00, 16'h00a5);
      acc(1'b0, 2'h0, 7'h0c, 8'h00, 16'h0000);
      acc(1'b1, 2'h0, 7'h08, 8'h1f, 16'h0);
      acc(1'b0, 2'h0, 7'h20, 8'h00, 16'h0000);
      acc(1'b1, 2'h0, 7'h05, 8'h20, 16'h0);
      acc(1'b1, 2'h0, 7'h04, 8'h50, 16'h0);
      acc(1'b0, 2'h1, 7'h00, 8'h00, 16'h00a5);
      acc(1'b1, 2'h0, 7'h0b, 8'h81, 16'h0);
      acc(1'b0, 2'h0, 7'h0b, 8'h00, 16'h0081);
      $display("banking test done");
      acc(1'b1, 2'h0, 7'h07, 8'hff, 16'h0);
      acc(1'b1, 2'h0, 7'h06, 8'h93, 16'h0);
      acc(1'b0, 2'h2, 7'h00, 8'h00, 16'h00cf);
      chk(16'h3f93, {1'b0, pa});
      chk(16'h0001, {15'h0, hef});
      acc(1'b1, 2'h2, 7'h00, 8'h00, 16'h0);
      acc(1'b0, 2'h2, 7'h00, 8'h00, 16'h00cf);
      $display("program read test done");
      acc(1'b1, 2'h0, 7'h03, 8'h03, 16'h0);
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h001b);
      cfo = 1'b1;
      acc(1'b1, 2'h0, 7'h03, 8'h00, 16'h0);
      cfo = 1'b0;
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h001f);
      pulse(6);
      acc(1'b1, 2'h0, 7'h03, 8'hff, 16'h0);
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h0017);
      pulse(8);
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h0007);
      pulse(7);
      fm = 3'h1;
      acc(1'b1, 2'h0, 7'h03, 8'h00, 16'h0);
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h001e);
      sub = 1'b1;
      @(negedge clk);
      acc(1'b0, 2'h0, 7'h03, 8'h00, 16'h001f);
      fm = 3'h0;
      sub = 1'b0;
      $display("status test done");
      pulse(4);
      chk(16'h0004, {1'b0, pc});
      repeat (15) pulse(2);
      chk(16'h0000, {15'h0, ovf});
      sre = 1'b1;
      pulse(2);
      chk(16'h0001, {15'h0, ovf});
      chk(16'h0001, {15'h0, srst});
      sre = 1'b0;
      pulse(9);
      chk(16'h0000, {15'h0, ovf});
      repeat (15) pulse(3);
      chk(16'h0004, {1'b0, pc});
      pulse(3);
      chk(16'h0000, {15'h0, unf});
      chk(16'h0000, {1'b0, pc});
      pulse(3);
      chk(16'h0001, {15'h0, unf});
      chk(16'h0000, {1'b0, pc});
      acc(1'b1, 2'h0, 7'h09, 8'h5a, 16'h0);
      pulse(4);
      acc(1'b1, 2'h0, 7'h09, 8'h3c, 16'h0);
      pulse(5);
      acc(1'b0, 2'h0, 7'h09, 8'h00, 16'h005a);
      $display("stack test done");
      end_sim();
   end
endmodule // tb_core_memory_organization
